// ==== shared/sar_adc_consts.svh ====
// constants for the converter control unit: register offsets, fields, reset values
// assumes inclusion by the package, the design file, the checker and the bench
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_RESULT_LOW 12'h000
`define OFF_RESULT_HIGH 12'h004
`define OFF_CONTROL 12'h008
`define OFF_CLOCK_SEL 12'h00c
`define OFF_IRQ_STATUS 12'h010
`define OFF_IRQ_MASK 12'h014
`define OFF_IRQ_ENABLES 12'h018

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTL_CHAN_LSB 0
`define CTL_PWR_LSB 3
`define CTL_EOC_BIT 6
`define CTL_START_BIT 7
`define CTL_RESET 8'h40

// ----------------------------------------
// clock select, interrupt enables, channel count and low data field position
// ----------------------------------------
`define CLKSEL_RESET 2'h1
`define IRQ_EN_GLOBAL 0
`define IRQ_EN_MFUNC1 1
`define IRQ_EN_CONV 2
`define NUM_CHANNELS 6
`define DATA_LOW_LSB 4

`endif

// ==== shared/sar_adc_pkg.sv ====
// types of the converter control unit
// assumes the constants header sits beside it
`include "sar_adc_consts.svh"
package sar_adc_pkg;
   // ----------------------------------------
   // conversion sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_reset = 2'b01,
      st_convert = 2'b10
   } conv_state_t;
endpackage : sar_adc_pkg

// ==== verilog/sar_adc_control_unit.sv ====
// control unit for a six channel 12-bit successive approximation converter
// assumes an apb master on pclk and an analog core answering on conv_done
//
// Operation
// R1: one of six analog inputs goes to the converter, picked by channel select.
// R2: result upper 8 bits in high register, low 4 bits in low bits 7..4.
// R3: power control all zero powers converter down, else it is powered up.
// R4: start bit rising then falling begins one conversion.
// R5: while start is high converter held in reset, end flag forced to 1.
// R6: end flag cleared to 0 by hardware when a conversion finishes.
// R7: conversion end sets the request flag; interrupt only when enabled.
// R8: interrupt needs global, multi-function 1 and converter enables all set.
// R9: after end flag falls both result registers hold the finished value.
// R10: converter clock is system clock divided by ratio from two select bits.
// R11: software pulses start after each channel change within ten instructions.
// R12: a proper start pulse leaves the end flag reliably high.
// R13: software keeps start low before beginning a conversion.
// R14: conversion runs in hardware while the processor continues.
// R15: channel change to all zeros needs no start pulse.
// R16: divider counter makes one-cycle enable at chosen ratio, default at reset.
// R17: results frozen during conversion, updated in the cycle end flag clears.
`timescale 1ns/1ps
`include "sar_adc_consts.svh"

module sar_adc_control_unit
   import sar_adc_pkg::*;
#(
   parameter int DATA_W = 12,
   parameter int DIV_W = 5
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog core
   output logic [2:0] conv_channel,
   output logic [5:0] conv_input_route,
   output logic conv_power_on,
   output logic conv_reset,
   output logic conv_start,
   output logic conv_clk_en,
   input wire logic conv_done,
   input wire logic [11:0] conv_data,
   // interrupt
   output logic irq
);

   // ----------------------------------------
   // elaboration checks
   // ----------------------------------------
   if (DATA_W != 12) begin : g_bad_width
      $error("converter result must be 12 bits");
   end
   if (DIV_W < 5) begin : g_bad_div
      $error("divider counter too narrow for ratio 32");
   end

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   logic wr_acc;
   logic rd_ok;
   assign wr_acc = psel && penable && pwrite;
   assign pready = 1'b1;
   assign rd_ok = hit(paddr, `OFF_RESULT_LOW) || hit(paddr, `OFF_RESULT_HIGH) ||
      hit(paddr, `OFF_CONTROL) || hit(paddr, `OFF_CLOCK_SEL) ||
      hit(paddr, `OFF_IRQ_STATUS) || hit(paddr, `OFF_IRQ_MASK) ||
      hit(paddr, `OFF_IRQ_ENABLES);
   // unmapped addresses answer with an error, data zero
   assign pslverr = psel && penable && !rd_ok;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [2:0] chan_q;
   logic [2:0] chan_d;
   logic [2:0] pwr_q;
   logic [2:0] pwr_d;
   logic start_q;
   logic start_d;
   logic eoc_q;
   logic eoc_d;
   logic [1:0] clksel_q;
   logic [1:0] clksel_d;
   logic [2:0] irq_en_q;
   logic [2:0] irq_en_d;
   logic status_q;
   logic status_d;
   logic mask_q;
   logic mask_d;
   logic [11:0] result_q;
   logic [11:0] result_d;
   conv_state_t state_q;
   conv_state_t state_d;
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] div_d;
   logic clk_en_q;
   logic clk_en_d;
   logic [DIV_W-1:0] div_last;
   logic done_evt;
   // reset image of the control byte, a constant so the reset branch stays pure
   localparam logic [7:0] CTL_RESET_V = `CTL_RESET;

   // ----------------------------------------
   // write strobes
   // ----------------------------------------
   logic wr_ctl;
   logic wr_csel;
   logic wr_mask;
   logic wr_en;
   logic wr_clr;
   assign wr_ctl = wr_acc && hit(paddr, `OFF_CONTROL);
   assign wr_csel = wr_acc && hit(paddr, `OFF_CLOCK_SEL);
   assign wr_mask = wr_acc && hit(paddr, `OFF_IRQ_MASK);
   assign wr_en = wr_acc && hit(paddr, `OFF_IRQ_ENABLES);
   // only a one in bit 0 clears the sticky flag
   assign wr_clr = wr_acc && hit(paddr, `OFF_IRQ_STATUS) && pwdata[0];

   // divide ratios 4, 8, 16, 32 for select 0..3
   always_comb begin
      div_last = DIV_W'((32'h4 << clksel_q) - 32'h1); // see R10
   end

   assign done_evt = (state_q == st_convert) && conv_done;

   // ----------------------------------------
   // clock divider
   // ----------------------------------------
   always_comb begin
      div_d = div_q + DIV_W'(1);
      clk_en_d = 1'b0;
      // >= so a smaller ratio written mid-count wraps at once
      if (div_q >= div_last) begin
         div_d = '0;
         clk_en_d = 1'b1; // see R16
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
         clk_en_q <= 1'b0;
      end else begin
         div_q <= div_d;
         clk_en_q <= clk_en_d;
      end
   end

   // ----------------------------------------
   // registers and sequencer
   // ----------------------------------------
   // sequencer follows the start bit as written, so the end flag
   // rises in the cycle right after the write
   always_comb begin
      chan_d = chan_q;
      pwr_d = pwr_q;
      start_d = start_q;
      eoc_d = eoc_q;
      clksel_d = clksel_q;
      irq_en_d = irq_en_q;
      status_d = status_q;
      mask_d = mask_q;
      result_d = result_q;
      state_d = state_q;
      // ----- software writes -----
      if (wr_ctl) begin
         chan_d = pwdata[`CTL_CHAN_LSB +: 3];
         pwr_d = pwdata[`CTL_PWR_LSB +: 3];
         start_d = pwdata[`CTL_START_BIT];
      end
      if (wr_csel) begin
         clksel_d = pwdata[1:0];
      end
      if (wr_mask) begin
         mask_d = pwdata[0];
      end
      if (wr_en) begin
         irq_en_d = pwdata[2:0];
      end
      if (wr_clr) begin
         status_d = 1'b0;
      end
      // ----- sequencer -----
      unique case (state_q)
         st_idle: begin
            if (start_d) begin
               state_d = st_reset;
               eoc_d = 1'b1; // see R5
            end
         end
         st_reset: begin
            eoc_d = 1'b1; // see R5
            if (!start_d) begin
               state_d = st_convert; // see R4
            end
         end
         st_convert: begin
            if (start_d) begin
               state_d = st_reset; // restart aborts, see R12
               eoc_d = 1'b1;
            end else if (conv_done) begin
               state_d = st_idle;
               eoc_d = 1'b0; // see R6
               result_d = conv_data; // see R17
            end
         end
         default: begin
            state_d = st_idle;
         end
      endcase
      // set beats a same-cycle clear
      if (done_evt && !start_d) begin
         status_d = 1'b1; // see R7
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_q <= CTL_RESET_V[`CTL_CHAN_LSB +: 3];
         pwr_q <= CTL_RESET_V[`CTL_PWR_LSB +: 3];
         start_q <= CTL_RESET_V[`CTL_START_BIT];
         eoc_q <= CTL_RESET_V[`CTL_EOC_BIT];
         clksel_q <= `CLKSEL_RESET; // see R16
         irq_en_q <= 3'h0;
         status_q <= 1'b0;
         mask_q <= 1'b0;
         result_q <= 12'h000;
         state_q <= st_idle;
      end else begin
         chan_q <= chan_d;
         pwr_q <= pwr_d;
         start_q <= start_d;
         eoc_q <= eoc_d;
         clksel_q <= clksel_d;
         irq_en_q <= irq_en_d;
         status_q <= status_d;
         mask_q <= mask_d;
         result_q <= result_d;
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // analog core controls
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `NUM_CHANNELS; gi++) begin : g_route
         // codes 6 and 7 route nothing
         assign conv_input_route[gi] = (chan_q == 3'(gi)); // see R1
      end
   endgenerate

   assign conv_channel = chan_q;
   assign conv_power_on = |pwr_q; // see R3
   assign conv_reset = (state_q == st_reset) || (state_q == st_idle); // see R5
   // core steps on the divided enable; cpu is never stalled, see R14
   assign conv_start = (state_q == st_convert);
   assign conv_clk_en = clk_en_q;

   // both enables plus global plus mask, see R8
   assign irq = status_q && mask_q && irq_en_q[`IRQ_EN_GLOBAL] &&
      irq_en_q[`IRQ_EN_MFUNC1] && irq_en_q[`IRQ_EN_CONV];

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         if (hit(paddr, `OFF_RESULT_LOW)) begin
            prdata[`DATA_LOW_LSB +: 4] = result_q[3:0]; // see R2, R9
         end else if (hit(paddr, `OFF_RESULT_HIGH)) begin
            prdata[7:0] = result_q[11:4]; // see R2
         end else if (hit(paddr, `OFF_CONTROL)) begin
            prdata[`CTL_CHAN_LSB +: 3] = chan_q;
            prdata[`CTL_PWR_LSB +: 3] = pwr_q;
            prdata[`CTL_EOC_BIT] = eoc_q;
            prdata[`CTL_START_BIT] = start_q;
         end else if (hit(paddr, `OFF_CLOCK_SEL)) begin
            prdata[1:0] = clksel_q;
         end else if (hit(paddr, `OFF_IRQ_STATUS)) begin
            prdata[0] = status_q;
         end else if (hit(paddr, `OFF_IRQ_MASK)) begin
            prdata[0] = mask_q;
         end else if (hit(paddr, `OFF_IRQ_ENABLES)) begin
            prdata[2:0] = irq_en_q;
         end
      end
   end

endmodule : sar_adc_control_unit

// ==== testbench/sar_adc_monitor.sv ====
// port checker for the converter control unit
// assumes binding onto sar_adc_control_unit, one clock
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_adc_monitor (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // core and interrupt
   input wire logic [2:0] conv_channel,
   input wire logic [5:0] conv_input_route,
   input wire logic conv_power_on,
   input wire logic conv_reset,
   input wire logic conv_start,
   input wire logic conv_clk_en,
   input wire logic conv_done,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_any = psel && penable && pwrite;
   wire ctl_wr = wr_any && paddr == `OFF_CONTROL;
   wire csel_wr = wr_any && paddr == `OFF_CLOCK_SEL;
   // irq may be registered once more after the status bit
   wire ev = conv_done || wr_any;
   AST_ROUTE: assert property (conv_input_route == (conv_channel < 3'h6 ? 6'h1 << conv_channel : 6'h0))
      else $error("route wrong");
   AST_CHAN: assert property (ctl_wr |=> conv_channel == $past(pwdata[2:0]))
      else $error("channel wrong");
   AST_PWR: assert property (ctl_wr |=> conv_power_on == |$past(pwdata[5:3]))
      else $error("power wrong");
   AST_GO: assert property ($rose(conv_start) |-> $past(ctl_wr && !pwdata[7]))
      else $error("start without falling bit");
   AST_EXCL: assert property (!(conv_reset && conv_start))
      else $error("reset during conversion");
   AST_DONE: assert property (conv_start && conv_done |=> conv_reset && !conv_start)
      else $error("no stop after done");
   AST_CLK: assert property (conv_clk_en && !csel_wr && !$past(csel_wr) |=> !conv_clk_en)
      else $error("enable too wide");
   AST_IRQ: assert property ($rose(irq) |-> $past(ev) || $past(ev, 2))
      else $error("irq without cause");
endmodule : sar_adc_monitor

bind sar_adc_control_unit sar_adc_monitor sar_adc_monitor_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .conv_channel(conv_channel), .conv_input_route(conv_input_route),
   .conv_power_on(conv_power_on), .conv_reset(conv_reset), .conv_start(conv_start),
   .conv_clk_en(conv_clk_en), .conv_done(conv_done), .irq(irq));

// ==== testbench/analog_core_model.sv ====
// behavioural analog core on the far side of the control unit
// assumes the same clock as the control unit
`timescale 1ns/1ps
module analog_core_model (
   // control side
   input wire logic pclk,
   input wire logic conv_start,
   input wire logic conv_clk_en,
   // bench side
   input wire logic [11:0] sample,
   input wire logic [3:0] ticks,
   // result
   output logic conv_done,
   output logic [11:0] conv_data
);
   logic [3:0] cnt_q = 4'h0;
   logic [11:0] junk_q = 12'h5a5;
   always @(posedge pclk) begin
      junk_q <= junk_q + 12'h3b7;
      if (!conv_start)
         cnt_q <= 4'h0;
      else if (conv_clk_en)
         cnt_q <= cnt_q + 4'h1;
   end
   // data valid only with done, a moving pattern otherwise
   assign conv_done = conv_start && cnt_q == ticks;
   assign conv_data = conv_done ? sample : junk_q;
endmodule : analog_core_model

// ==== testbench/testbench.sv ====
// self-checking bench for the converter control unit
// assumes the analog core model and the bound checker
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module testbench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h0, sample = 12'h0, prev = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, cw;
   logic [3:0] ticks = 4'h4;
   logic pready, pslverr, conv_power_on, conv_reset, conv_start, conv_clk_en, conv_done, irq;
   logic [2:0] conv_channel;
   logic [5:0] conv_input_route;
   logic [11:0] conv_data;
   int n_errors = 0, n_tests = 0, seed = 32'h66d2, i, k, en, msk;
   always #5 pclk = ~pclk;
   sar_adc_control_unit sar_adc_control_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_channel(conv_channel),
      .conv_input_route(conv_input_route), .conv_power_on(conv_power_on),
      .conv_reset(conv_reset), .conv_start(conv_start), .conv_clk_en(conv_clk_en),
      .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
   analog_core_model analog_core_model_inst (.pclk(pclk), .conv_start(conv_start),
      .conv_clk_en(conv_clk_en), .sample(sample), .ticks(ticks), .conv_done(conv_done),
      .conv_data(conv_data));
   // ---
   // tasks
   // ---
   task chk(input string w, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   // low result byte image: four data bits on top, the rest read zero
   function automatic logic [31:0] lo_image(input logic [11:0] s);
      lo_image = {24'h0, s[3:0], 4'h0};
   endfunction : lo_image
   // an idle cycle between transfers keeps each signal to one update a step
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdc(input string w, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(w, e, rd);
   endtask : rdc
   task print_verdict();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      #300000;
      n_errors++;
      print_verdict();
   end
   // ---
   // scenarios
   // ---
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctl", `OFF_CONTROL, 32'h40);
      rdc("csel", `OFF_CLOCK_SEL, 32'h1);
      apb(1'b0, 12'h01c, 32'h0);
      chk("slverr", 1, err);
      for (i = 3; i >= 0; i--) begin
         apb(1'b1, `OFF_CLOCK_SEL, i);
         // first pulse after a change may be short
         repeat (2) @(posedge conv_clk_en);
         @(negedge pclk);
         k = 0;
         do begin @(negedge pclk); k++; end while (conv_clk_en !== 1'b1);
         chk("period", 4 << i, k);
      end
      for (i = 0; i < 12; i++) begin
         k = (i < 6) ? i : $unsigned($random(seed)) % 6;
         en = (i < 8) ? i : 7;
         msk = (i < 8) || i[0];
         sample <= $random(seed);
         ticks <= 4'h4 + $unsigned($random(seed)) % 10;
         cw = k + ((i % 7 + 1) << 3);
         apb(1'b1, `OFF_IRQ_ENABLES, en);
         apb(1'b1, `OFF_IRQ_MASK, msk);
         apb(1'b1, `OFF_CONTROL, cw);
         apb(1'b1, `OFF_CONTROL, cw | 32'h80);
         rdc("eoc", `OFF_CONTROL, cw | 32'hc0);
         chk("route", 6'h1 << k, conv_input_route);
         chk("pwr", 1, conv_power_on);
         apb(1'b1, `OFF_CONTROL, cw);
         if (i == 3) begin
            apb(1'b1, `OFF_CONTROL, cw | 32'h80);
            rdc("abort", `OFF_CONTROL, cw | 32'hc0);
            apb(1'b1, `OFF_CONTROL, cw);
         end
         rdc("armed", `OFF_CONTROL, cw | 32'h40);
         rdc("hold", `OFF_RESULT_HIGH, prev[11:4]);
         do apb(1'b0, `OFF_CONTROL, 32'h0); while (rd[6] !== 1'b0);
         chk("ctl", cw, rd);
         prev = sample;
         rdc("hi", `OFF_RESULT_HIGH, sample[11:4]);
         rdc("lo", `OFF_RESULT_LOW, lo_image(sample));
         rdc("stat", `OFF_IRQ_STATUS, 32'h1);
         chk("irq", en == 7 && msk, irq);
         apb(1'b1, `OFF_IRQ_STATUS, 32'h1);
         rdc("clr", `OFF_IRQ_STATUS, 32'h0);
         chk("irq", 0, irq);
      end
      apb(1'b1, `OFF_CONTROL, 32'h0);
      rdc("off", `OFF_CONTROL, 32'h0);
      chk("pwr", 0, conv_power_on);
      print_verdict();
   end
endmodule : testbench
